// *** rtl/cmpr_pkg.sv ***
// Package for the comparator interrupt and result register slice.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one clock.
package cmpr_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_IRQ_ENABLE_COMBINED = 12'h300; // Enable bits, plain RW
  localparam logic [11:0] OFF_IRQ_ENABLE_SET = 12'h304; // Write one to enable
  localparam logic [11:0] OFF_IRQ_ENABLE_CLEAR = 12'h308; // Write one to disable
  localparam logic [11:0] OFF_EVENT_STATUS = 12'h310; // Sticky events, write one clears
  localparam logic [11:0] OFF_EVENT_MASK = 12'h314; // Event mask for IRQ line
  localparam logic [11:0] OFF_COMPARE_OUTCOME = 12'h400; // Last sampled result
  localparam logic [11:0] OFF_COMPARATOR_ENABLE = 12'h500; // Comparator enable
  localparam logic [11:0] OFF_INPUT_CHANNEL_SELECT = 12'h504; // Input select

  // ----------------------------------------
  // Field layouts and reset values
  // ----------------------------------------
  localparam int EV_READY = 0; // Ready event bit
  localparam int EV_DOWN = 1; // Downward crossing bit
  localparam int EV_UP = 2; // Upward crossing bit
  localparam int EV_CROSS = 3; // Any crossing bit
  localparam int NUM_EV = 4; // Number of events
  localparam logic [3:0] RST_IRQ_EN = 4'h0; // Enables after reset
  localparam logic [3:0] RST_MASK = 4'hF; // Mask after reset, all pass
  localparam logic [2:0] RST_PSEL = 3'h0; // Channel zero after reset
  localparam logic [1:0] RST_ENABLE = 2'h0; // Comparator off after reset
  localparam logic [3:0] RST_STATUS = 4'h0; // No events after reset
  localparam logic RST_RESULT = 1'h0; // Result reads below after reset
  localparam logic [7:0] RST_CHAN_ONEHOT = 8'h01; // Channel zero routed after reset
  localparam logic [31:0] RST_RDATA = 32'h0000_0000; // Read data after reset
  localparam logic [2:0] SEL_HALF_SUPPLY = 3'h7; // Code routing half supply
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000; // Read of a hole

  // ----------------------------------------
  // Bus answer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, // Waiting for a request
    ST_ACK = 2'b10 // Answering, waitrequest low
  } cmpr_state_t;

  // All state of the top module
  typedef struct packed {
    cmpr_state_t st; // Bus state
    logic [3:0] irq_en; // Interrupt enables
    logic [3:0] status; // Sticky event flags
    logic [3:0] mask; // Event mask
    logic result; // Latched compare outcome
    logic [1:0] enable; // Comparator enable field
    logic [2:0] psel; // Input select code
    logic [7:0] chan_onehot; // Routed analog channel, one-hot
    logic half_supply; // Half supply routed
    logic [31:0] rdata; // Read data
    logic irq; // Interrupt output
  } cmpr_regs_t;

endpackage

// *** rtl/cmpr_regs.sv ***
// Comparator interrupt-enable, result and input-select register slice.
// Assumes an Avalon-MM master on REF_CLK and an analog core giving events.
//
// Contract
// - Set bit0 enables ready interrupt; reads state
// - Set bit1 enables downward interrupt; reads state
// - Set bit2 enables upward interrupt; reads state
// - Set bit3 enables crossing interrupt; reads state
// - Clear bit0 disables ready interrupt; reads state
// - Clear bit1 disables downward interrupt; reads state
// - Clear bit2 disables upward interrupt; reads state
// - Clear bit3 disables crossing interrupt; reads state
// - Result latched on sample, held until next
// - Result zero when positive input below
// - Result one when positive input above
// - Codes zero to six route channel N
// - Code seven routes half supply
// - Combined register shares the four enables
`timescale 1ns/10ps

module cmpr_regs (
  input wire logic REF_CLK, // System clock, 10 MHz
  input wire logic RST_B, // Async reset, active low
  input wire logic [11:0] AVS_ADDRESS, // Byte address
  input wire logic AVS_READ, // Read request
  input wire logic AVS_WRITE, // Write request
  input wire logic [31:0] AVS_WRITEDATA, // Write data
  input wire logic [3:0] AVS_BYTEENABLE, // Byte lanes
  output logic [31:0] AVS_READDATA, // Read data
  output logic AVS_WAITREQUEST, // Stall, high until answer
  input wire logic SAMPLE_TASK, // Sample pulse
  input wire logic COMP_ABOVE, // Positive input above negative
  input wire logic [3:0] EVENT_PULSE, // Ready, down, up, cross pulses
  output logic [7:0] ANALOG_CHANNEL_SEL, // One-hot analog channel route
  output logic HALF_SUPPLY_INPUT, // Half supply routed
  output logic [1:0] COMPARATOR_ENABLE, // Comparator enable field
  output logic IRQ // Level interrupt
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Address hit for a word offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  cmpr_pkg::cmpr_regs_t r_q; // Registered state
  cmpr_pkg::cmpr_regs_t r_d; // Next state
  logic req; // Request pending
  logic wr_go; // Write takes effect
  logic [3:0] wlow; // Low write nibble, lane 0

  assign req = AVS_READ | AVS_WRITE;
  // Write lands only at the edge where the master sees waitrequest low
  assign wr_go = AVS_WRITE && (r_q.st == cmpr_pkg::ST_ACK);
  assign wlow = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[3:0] : 4'h0;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.irq = 1'b0;
    // Bus handshake: one idle cycle then answer
    case (r_q.st)
      cmpr_pkg::ST_IDLE: begin
        if (req) begin
          r_d.st = cmpr_pkg::ST_ACK;
        end
      end
      cmpr_pkg::ST_ACK: begin
        r_d.st = cmpr_pkg::ST_IDLE;
      end
      default: begin
        r_d.st = cmpr_pkg::ST_IDLE;
      end
    endcase
    // Read mux, captured the cycle before the answer
    if (AVS_READ && (r_q.st == cmpr_pkg::ST_IDLE)) begin
      if (hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_COMBINED) ||
          hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_SET) ||
          hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_CLEAR)) begin
        r_d.rdata = {28'h0, r_q.irq_en};
      end else if (hit(AVS_ADDRESS, cmpr_pkg::OFF_EVENT_STATUS)) begin
        r_d.rdata = {28'h0, r_q.status};
      end else if (hit(AVS_ADDRESS, cmpr_pkg::OFF_EVENT_MASK)) begin
        r_d.rdata = {28'h0, r_q.mask};
      end else if (hit(AVS_ADDRESS, cmpr_pkg::OFF_COMPARE_OUTCOME)) begin
        r_d.rdata = {31'h0, r_q.result};
      end else if (hit(AVS_ADDRESS, cmpr_pkg::OFF_COMPARATOR_ENABLE)) begin
        r_d.rdata = {30'h0, r_q.enable};
      end else if (hit(AVS_ADDRESS, cmpr_pkg::OFF_INPUT_CHANNEL_SELECT)) begin
        r_d.rdata = {29'h0, r_q.psel};
      end else begin
        r_d.rdata = cmpr_pkg::UNMAPPED_DATA;
      end
    end
    // Register writes
    if (wr_go) begin
      if (hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_COMBINED)) begin
        r_d.irq_en = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[3:0] : r_q.irq_en;
      end
      if (hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_SET)) begin
        r_d.irq_en = r_q.irq_en | wlow;
      end
      if (hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_CLEAR)) begin
        r_d.irq_en = r_q.irq_en & ~wlow;
      end
      if (hit(AVS_ADDRESS, cmpr_pkg::OFF_EVENT_STATUS)) begin
        r_d.status = r_q.status & ~wlow;
      end
      if (hit(AVS_ADDRESS, cmpr_pkg::OFF_EVENT_MASK) && AVS_BYTEENABLE[0]) begin
        r_d.mask = AVS_WRITEDATA[3:0];
      end
      if (hit(AVS_ADDRESS, cmpr_pkg::OFF_COMPARATOR_ENABLE) && AVS_BYTEENABLE[0]) begin
        r_d.enable = AVS_WRITEDATA[1:0];
      end
      if (hit(AVS_ADDRESS, cmpr_pkg::OFF_INPUT_CHANNEL_SELECT) && AVS_BYTEENABLE[0]) begin
        r_d.psel = AVS_WRITEDATA[2:0];
      end
    end
    // Events set sticky flags; set wins over clear
    r_d.status = r_d.status | EVENT_PULSE;
    // Sample latches comparator outcome
    if (SAMPLE_TASK) begin
      r_d.result = COMP_ABOVE;
    end
    // Input routing from select code
    r_d.chan_onehot = 8'h00;
    r_d.half_supply = (r_d.psel == cmpr_pkg::SEL_HALF_SUPPLY);
    if (!r_d.half_supply) begin
      r_d.chan_onehot[r_d.psel] = 1'b1;
    end
    // Interrupt from enabled, unmasked flags
    r_d.irq = |(r_d.status & r_d.irq_en & r_d.mask);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      r_q.st <= cmpr_pkg::ST_IDLE;
      r_q.irq_en <= cmpr_pkg::RST_IRQ_EN;
      r_q.status <= cmpr_pkg::RST_STATUS;
      r_q.mask <= cmpr_pkg::RST_MASK;
      r_q.result <= cmpr_pkg::RST_RESULT;
      r_q.enable <= cmpr_pkg::RST_ENABLE;
      r_q.psel <= cmpr_pkg::RST_PSEL;
      r_q.chan_onehot <= cmpr_pkg::RST_CHAN_ONEHOT;
      r_q.half_supply <= 1'b0;
      r_q.rdata <= cmpr_pkg::RST_RDATA;
      r_q.irq <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flip-flops
  assign AVS_READDATA = r_q.rdata;
  assign AVS_WAITREQUEST = r_q.st[0]; // Idle code holds bit 0, so high unless answering
  assign ANALOG_CHANNEL_SEL = r_q.chan_onehot;
  assign HALF_SUPPLY_INPUT = r_q.half_supply;
  assign COMPARATOR_ENABLE = r_q.enable;
  assign IRQ = r_q.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_set_enables;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_SET) && wlow[0]
      |=> r_q.irq_en[0];
  endproperty
  a_set_enables: assert property (p_set_enables) else $error("set failed");

  property p_set_down;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_SET) && wlow[1]
      |=> r_q.irq_en[1];
  endproperty
  a_set_down: assert property (p_set_down) else $error("down set failed");

  property p_clr_disables;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_CLEAR) && wlow[3]
      |=> !r_q.irq_en[3];
  endproperty
  a_clr_disables: assert property (p_clr_disables) else $error("clear failed");

  property p_zero_keeps;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_SET) && !wlow[2]
      |=> r_q.irq_en[2] == $past(r_q.irq_en[2]);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero changed enable");

  property p_result_hold;
    @(posedge REF_CLK) disable iff (!RST_B)
      !SAMPLE_TASK |=> $stable(r_q.result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved");

  property p_result_val;
    @(posedge REF_CLK) disable iff (!RST_B)
      SAMPLE_TASK |=> r_q.result == $past(COMP_ABOVE);
  endproperty
  a_result_val: assert property (p_result_val) else $error("result wrong");

  property p_route;
    @(posedge REF_CLK) disable iff (!RST_B)
      r_q.psel != cmpr_pkg::SEL_HALF_SUPPLY |-> ANALOG_CHANNEL_SEL[r_q.psel] && !HALF_SUPPLY_INPUT;
  endproperty
  a_route: assert property (p_route) else $error("channel route wrong");

  property p_half;
    @(posedge REF_CLK) disable iff (!RST_B)
      r_q.psel == cmpr_pkg::SEL_HALF_SUPPLY |-> HALF_SUPPLY_INPUT && ANALOG_CHANNEL_SEL == 8'h00;
  endproperty
  a_half: assert property (p_half) else $error("half supply route wrong");

  property p_irq;
    @(posedge REF_CLK) disable iff (!RST_B)
      ##1 IRQ == |(r_q.status & r_q.irq_en & r_q.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_combined;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && AVS_BYTEENABLE[0] && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_COMBINED)
      |=> r_q.irq_en == $past(AVS_WRITEDATA[3:0]);
  endproperty
  a_combined: assert property (p_combined) else $error("combined write failed");

  // ----------------------------------------
  // Per-bit enable checks, plus result, select and event flag checks
  // ----------------------------------------
  property p_set_up;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_SET) && wlow[2]
      |=> r_q.irq_en[2];
  endproperty
  a_set_up: assert property (p_set_up) else $error("up set failed");

  property p_set_cross;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_SET) && wlow[3]
      |=> r_q.irq_en[3];
  endproperty
  a_set_cross: assert property (p_set_cross) else $error("cross set failed");

  property p_clr_ready;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_CLEAR) && wlow[0]
      |=> !r_q.irq_en[0];
  endproperty
  a_clr_ready: assert property (p_clr_ready) else $error("ready clear failed");

  property p_clr_down;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_CLEAR) && wlow[1]
      |=> !r_q.irq_en[1];
  endproperty
  a_clr_down: assert property (p_clr_down) else $error("down clear failed");

  property p_clr_up;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_CLEAR) && wlow[2]
      |=> !r_q.irq_en[2];
  endproperty
  a_clr_up: assert property (p_clr_up) else $error("up clear failed");

  property p_clr_zero_keeps;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_CLEAR) && !wlow[1]
      |=> r_q.irq_en[1] == $past(r_q.irq_en[1]);
  endproperty
  a_clr_zero_keeps: assert property (p_clr_zero_keeps) else $error("zero clear moved");

  property p_combined_lane;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && !AVS_BYTEENABLE[0] && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_COMBINED)
      |=> $stable(r_q.irq_en);
  endproperty
  a_combined_lane: assert property (p_combined_lane) else $error("lane off wrote");

  property p_result_low;
    @(posedge REF_CLK) disable iff (!RST_B)
      SAMPLE_TASK && !COMP_ABOVE |=> !r_q.result;
  endproperty
  a_result_low: assert property (p_result_low) else $error("result not low");

  property p_psel_write;
    @(posedge REF_CLK) disable iff (!RST_B)
      wr_go && AVS_BYTEENABLE[0] && hit(AVS_ADDRESS, cmpr_pkg::OFF_INPUT_CHANNEL_SELECT)
      |=> r_q.psel == $past(AVS_WRITEDATA[2:0]);
  endproperty
  a_psel_write: assert property (p_psel_write) else $error("select write failed");

  property p_status_set;
    @(posedge REF_CLK) disable iff (!RST_B)
      |EVENT_PULSE |=> (r_q.status & $past(EVENT_PULSE)) == $past(EVENT_PULSE);
  endproperty
  a_status_set: assert property (p_status_set) else $error("event flag lost");

  // ----------------------------------------
  // Bus timing and read-back checks
  // ----------------------------------------
  property p_wait_answer;
    @(posedge REF_CLK) disable iff (!RST_B)
      (AVS_READ || AVS_WRITE) && (r_q.st == cmpr_pkg::ST_IDLE) |=> !AVS_WAITREQUEST;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer after take");

  property p_wait_one;
    @(posedge REF_CLK) disable iff (!RST_B)
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer held too long");

  property p_rd_set;
    @(posedge REF_CLK) disable iff (!RST_B)
      AVS_READ && (r_q.st == cmpr_pkg::ST_IDLE)
      && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_SET)
      |=> AVS_READDATA == {28'h0, $past(r_q.irq_en)};
  endproperty
  a_rd_set: assert property (p_rd_set) else $error("set read wrong");

  property p_rd_clear;
    @(posedge REF_CLK) disable iff (!RST_B)
      AVS_READ && (r_q.st == cmpr_pkg::ST_IDLE)
      && hit(AVS_ADDRESS, cmpr_pkg::OFF_IRQ_ENABLE_CLEAR)
      |=> AVS_READDATA == {28'h0, $past(r_q.irq_en)};
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("clear read wrong");

  property p_rd_result;
    @(posedge REF_CLK) disable iff (!RST_B)
      AVS_READ && (r_q.st == cmpr_pkg::ST_IDLE)
      && hit(AVS_ADDRESS, cmpr_pkg::OFF_COMPARE_OUTCOME)
      |=> AVS_READDATA == {31'h0, $past(r_q.result)};
  endproperty
  a_rd_result: assert property (p_rd_result) else $error("result read wrong");

endmodule

// *** dv/tb.sv ***
// Self-checking bench for the comparator interrupt and result register slice.
// Assumes cmpr_pkg is compiled first; the bench alone drives every input.
`timescale 1ns/10ps
module tb;
  logic ref_clk, rst_b, avs_read, avs_write, sample_task, comp_above, avs_waitrequest;
  logic half_supply_input, irq;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic [3:0] avs_byteenable, event_pulse;
  logic [7:0] analog_channel_sel;
  logic [1:0] comparator_enable;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int errors = 0;
  int checked = 0;
  cmpr_regs dut (.REF_CLK(ref_clk), .RST_B(rst_b), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .SAMPLE_TASK(sample_task), .COMP_ABOVE(comp_above),
    .EVENT_PULSE(event_pulse), .ANALOG_CHANNEL_SEL(analog_channel_sel),
    .HALF_SUPPLY_INPUT(half_supply_input), .COMPARATOR_ENABLE(comparator_enable), .IRQ(irq));
  // ----------------------------------------
  // Clock, helpers and checks
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Xorshift source for random write data
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out();
    $display("counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      cmp(1'b1, 1'b0, "bus answer timeout");
      close_out();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
  endtask
  // Read data monitor, compares each answered read with the oldest note
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) cmp(1'b1, 1'b0, "read without note");
      else cmp(avs_readdata, exp_q.pop_front(), "read data");
    end
  end
  // Watchdog
  initial begin
    #400000;
    cmp(1'b1, 1'b0, "watchdog");
    close_out();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [3:0] en;
    rst_b = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 12'h000;
    avs_writedata = 32'h0; avs_byteenable = 4'hF; sample_task = 1'b0; comp_above = 1'b0;
    event_pulse = 4'h0; seed = 32'd56; en = 4'h0;
    repeat (6) @(posedge ref_clk);
    cmp(analog_channel_sel, 8'h01, "sel in reset");
    cmp(irq, 1'b0, "irq in reset");
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(cmpr_pkg::OFF_IRQ_ENABLE_SET, 32'h0);
    rd(cmpr_pkg::OFF_COMPARE_OUTCOME, 32'h0);
    rd(cmpr_pkg::OFF_INPUT_CHANNEL_SELECT, 32'h0);
    rd(cmpr_pkg::OFF_EVENT_MASK, 32'h0000_000F);
    rd(12'h600, cmpr_pkg::UNMAPPED_DATA);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      en[i] = 1'b1;
      bus(cmpr_pkg::OFF_IRQ_ENABLE_SET, 1'b1, 32'h1 << i);
      rd(cmpr_pkg::OFF_IRQ_ENABLE_SET, {28'h0, en});
      rd(cmpr_pkg::OFF_IRQ_ENABLE_CLEAR, {28'h0, en});
      rd(cmpr_pkg::OFF_IRQ_ENABLE_COMBINED, {28'h0, en});
    end
    bus(cmpr_pkg::OFF_IRQ_ENABLE_CLEAR, 1'b1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      en[i] = 1'b0;
      bus(cmpr_pkg::OFF_IRQ_ENABLE_CLEAR, 1'b1, 32'h1 << i);
      rd(cmpr_pkg::OFF_IRQ_ENABLE_CLEAR, {28'h0, en});
    end
    seed = xs(seed);
    bus(cmpr_pkg::OFF_IRQ_ENABLE_COMBINED, 1'b1, seed);
    bus(cmpr_pkg::OFF_IRQ_ENABLE_SET, 1'b1, 32'h0);
    rd(cmpr_pkg::OFF_IRQ_ENABLE_SET, {28'h0, seed[3:0]});
    bus(cmpr_pkg::OFF_IRQ_ENABLE_CLEAR, 1'b1, 32'hF);
    avs_byteenable <= 4'hE;
    bus(cmpr_pkg::OFF_IRQ_ENABLE_COMBINED, 1'b1, 32'hF);
    avs_byteenable <= 4'hF;
    rd(cmpr_pkg::OFF_IRQ_ENABLE_COMBINED, 32'h0);
    $display("test enable set and clear done");
    comp_above <= 1'b1;
    sample_task <= 1'b1;
    @(posedge ref_clk);
    sample_task <= 1'b0;
    comp_above <= 1'b0;
    @(posedge ref_clk);
    rd(cmpr_pkg::OFF_COMPARE_OUTCOME, 32'h1);
    bus(cmpr_pkg::OFF_COMPARE_OUTCOME, 1'b1, 32'h0);
    rd(cmpr_pkg::OFF_COMPARE_OUTCOME, 32'h1);
    sample_task <= 1'b1;
    @(posedge ref_clk);
    sample_task <= 1'b0;
    @(posedge ref_clk);
    rd(cmpr_pkg::OFF_COMPARE_OUTCOME, 32'h0);
    $display("test compare outcome done");
    for (int c = 0; c < 8; c++) begin
      bus(cmpr_pkg::OFF_INPUT_CHANNEL_SELECT, 1'b1, c);
      rd(cmpr_pkg::OFF_INPUT_CHANNEL_SELECT, c);
      cmp(analog_channel_sel, (c == 7) ? 8'h00 : 8'h01 << c, "channel");
      cmp(half_supply_input, c == 7, "half supply");
    end
    bus(cmpr_pkg::OFF_COMPARATOR_ENABLE, 1'b1, 32'h3);
    cmp(comparator_enable, 2'h3, "comparator enable");
    rd(cmpr_pkg::OFF_COMPARATOR_ENABLE, 32'h3);
    $display("test input select done");
    for (int i = 0; i < 4; i++) begin
      event_pulse <= 4'h1 << i;
      @(posedge ref_clk);
      event_pulse <= 4'h0;
      settle();
      cmp(irq, 1'b0, "irq while disabled");
      rd(cmpr_pkg::OFF_EVENT_STATUS, 32'h1 << i);
      bus(cmpr_pkg::OFF_IRQ_ENABLE_SET, 1'b1, 32'h1 << i);
      settle();
      cmp(irq, 1'b1, "irq enabled");
      bus(cmpr_pkg::OFF_EVENT_MASK, 1'b1, 32'h0);
      settle();
      cmp(irq, 1'b0, "irq masked");
      bus(cmpr_pkg::OFF_EVENT_MASK, 1'b1, 32'hF);
      bus(cmpr_pkg::OFF_IRQ_ENABLE_CLEAR, 1'b1, 32'h1 << i);
      settle();
      cmp(irq, 1'b0, "irq after clear");
      bus(cmpr_pkg::OFF_EVENT_STATUS, 1'b1, 32'h1 << i);
      bus(cmpr_pkg::OFF_IRQ_ENABLE_SET, 1'b1, 32'h1 << i);
      settle();
      cmp(irq, 1'b0, "irq after status clear");
      bus(cmpr_pkg::OFF_IRQ_ENABLE_CLEAR, 1'b1, 32'h1 << i);
    end
    $display("test interrupt done");
    close_out();
  end
endmodule
